// [src/scl_pkg.sv]
// Constants, register map and types for the SERDES clocking control block
package scl_pkg;
  localparam int ADDR_W = 14; // AXI byte address width
  localparam int IDX_W = 12; // Register index width
  localparam int TUNE_N = 15; // Number of PLL tuning registers
  localparam int LANES = 8; // Serial lanes
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_INT_EN = 12'h01F;
  localparam logic [11:0] IDX_INT_ST = 12'h023;
  localparam logic [11:0] IDX_IF_PD = 12'h200;
  localparam logic [11:0] IDX_LANE_PD = 12'h201;
  localparam logic [11:0] IDX_CDR_RST = 12'h206;
  localparam logic [11:0] IDX_SAMP = 12'h230;
  localparam logic [11:0] IDX_EQ = 12'h268;
  localparam logic [11:0] IDX_PLL_CTL = 12'h280;
  localparam logic [11:0] IDX_PLL_ST = 12'h281;
  localparam logic [11:0] IDX_DIV = 12'h289;
  localparam logic [11:0] IDX_FRAME = 12'h3F0; // Octets per frame
  // Tuning register indices, slot 14 first and slot 0 last
  localparam logic [14:0][11:0] TUNE_IDX = {
    12'h2A0, 12'h29F, 12'h29C, 12'h29A, 12'h299, 12'h297, 12'h296,
    12'h294, 12'h290, 12'h28B, 12'h28A, 12'h287, 12'h286, 12'h285,
    12'h284};
  localparam logic [7:0] RST_VAL = 8'h00; // Reset value of RW regs without their own reset constant
  localparam logic [7:0] RST_IF_PD = 8'h01; // Interface starts off
  localparam logic [7:0] RST_FRAME = 8'h01; // F of one
  // Field positions
  localparam int PLL_EN_BIT = 0;
  localparam int RECAL_BIT = 2;
  localparam int LOCK_BIT = 0;
  localparam int CAL_OK_BIT = 3;
  localparam int BAND_HI_BIT = 4;
  localparam int BAND_LO_BIT = 5;
  localparam int IRQ_LOCK_BIT = 2;
  localparam int IRQ_LOST_BIT = 3;
  localparam int HALF_BIT = 5;
  localparam int OVS_BIT = 1;
  localparam int CDR_RST_BIT = 0;
  localparam int EQ_LSB = 6;
  localparam logic [1:0] EQ_LOW_POWER = 2'h1;
  localparam logic [1:0] EQ_NORMAL = 2'h0;
  // Divider codes and their ratios
  localparam logic [1:0] DIV_SEL_1 = 2'h2;
  localparam logic [1:0] DIV_SEL_2 = 2'h1;
  localparam logic [1:0] DIV_SEL_4 = 2'h0;
  // Clock relationships
  localparam int BITS_PER_BYTE = 10;
  localparam int LANE_RATE_MULT = 20;
  localparam int BYTES_PER_PCLK = 4;
  localparam int REF_DIV_OF_LANE = 40;
  localparam logic [1:0] VCO_POST_DIV = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_TIME_NS = 10000; // Calibration run time
  localparam int CAL_CYCLES = CAL_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_RUN = 2'h1,
    CAL_DONE = 2'h2
  } scl_cal_type;
endpackage

// [src/scl_top.sv]
// SERDES PLL, recovery and lane front-end control with AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module scl_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [scl_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [scl_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_pll_lock_det,
  input wire logic i_cal_band_hi,
  input wire logic i_cal_band_lo,
  output logic o_if_power_down,
  output logic [scl_pkg::LANES-1:0] o_lane_power_down,
  output logic o_pll_enable,
  output logic [1:0] o_pll_divider_select,
  output logic [2:0] o_reference_divide_ratio,
  output logic [1:0] o_vco_post_divide,
  output logic o_cal_start,
  output logic o_pll_locked,
  output logic o_half_rate_sampling_on,
  output logic o_double_oversampling_on,
  output logic [scl_pkg::LANES-1:0] o_lane_cdr_reset,
  output logic [1:0] o_equalizer_power_select,
  output logic [2:0] o_frames_per_processing_clock
);
  import scl_pkg::*;

  // Whole state of the block in one record
  typedef struct packed {
    logic aw_got; // Write address held
    logic [IDX_W-1:0] aw_idx;
    logic w_got; // Write data held
    logic [7:0] w_data;
    logic w_be; // Low byte lane enabled
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] int_en;
    logic [7:0] int_st;
    logic [7:0] if_pd;
    logic [7:0] lane_pd;
    logic [7:0] cdr_rst;
    logic [7:0] samp;
    logic [7:0] eq;
    logic [7:0] pll_ctl;
    logic [7:0] div;
    logic [7:0] frame;
    logic [TUNE_N-1:0][7:0] tune;
    scl_cal_type cal_state;
    logic [CNT_W-1:0] cal_cnt;
    logic cal_ok; // Calibration finished cleanly
    logic en_prev;
    logic recal_prev;
    logic [2:0] s1; // Pin synchroniser stages
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt; // Agreed pin levels
    logic if_pd_o;
    logic [LANES-1:0] lane_pd_o;
    logic pll_en_o;
    logic [1:0] div_sel_o;
    logic [2:0] ratio_o;
    logic cal_start;
    logic locked;
    logic half_o;
    logic ovs_o;
    logic [LANES-1:0] cdr_rst_o;
    logic [1:0] eq_o;
    logic [2:0] fpp_o;
  } scl_state_type;

  scl_state_type r_reg; // Registered state
  scl_state_type r_next; // Next state

  // Tuning slot lookup: slot plus one, zero when not a tuning register
  function automatic logic [4:0] tune_slot(input logic [IDX_W-1:0] idx);
    logic [4:0] s;
    s = 5'h00;
    for (int k = 0; k < TUNE_N; k++) begin
      if (TUNE_IDX[k] == idx) begin
        s = 5'(k + 1);
      end
    end
    return s;
  endfunction

  // Divider code to reference divide ratio; spare code 3 acts as 0
  function automatic logic [2:0] ref_ratio(input logic [1:0] sel);
    logic [2:0] v;
    v = 3'h4;
    if (sel == DIV_SEL_1) begin
      v = 3'h1;
    end else if (sel == DIV_SEL_2) begin
      v = 3'h2;
    end
    return v;
  endfunction

  // Frame clocks per processing clock: four over F for F of one, two or four, else one
  function automatic logic [2:0] frames_per_pclk(input logic [7:0] f);
    logic [2:0] v;
    v = 3'h1;
    if (f == 8'h01) begin
      v = 3'(BYTES_PER_PCLK);
    end else if (f == 8'h02) begin
      v = 3'(BYTES_PER_PCLK / 2);
    end
    return v;
  endfunction

  logic [4:0] wslot; // Tuning slot of the held write
  logic [4:0] rslot; // Tuning slot of the read address
  logic [IDX_W-1:0] ridx; // Read register index
  logic lock_ev; // Lock gained this cycle
  logic lost_ev; // Lock lost this cycle
  logic start_ev; // Calibration start request

  // Next-state logic: bus slave, registers, calibration, outputs
  always_comb begin
    r_next = r_reg;
    wslot = tune_slot(r_reg.aw_idx);
    ridx = i_araddr[ADDR_W-1:2];
    rslot = tune_slot(ridx);
    // Pins pass three stages; a level counts once stage two and three agree
    r_next.s1 = {i_cal_band_lo, i_cal_band_hi, i_pll_lock_det};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.filt = (r_reg.s2 & r_reg.s3) | (r_reg.filt & (r_reg.s2 ^ r_reg.s3));
    // Address and data are taken independently, in either order
    if (i_awvalid && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.aw_idx = i_awaddr[ADDR_W-1:2];
    end
    if (i_wvalid && r_reg.wready) begin
      r_next.w_got = 1'b1;
      r_next.w_data = i_wdata[7:0];
      r_next.w_be = i_wstrb[0];
    end
    if (r_reg.bvalid && i_bready) begin
      r_next.bvalid = 1'b0;
    end
    // Commit a write once both halves are held
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      unique case (r_reg.aw_idx)
        IDX_INT_EN: if (r_reg.w_be) r_next.int_en = r_reg.w_data;
        // Writing one clears a sticky event bit
        IDX_INT_ST: if (r_reg.w_be) begin
          r_next.int_st = r_reg.int_st & ~r_reg.w_data;
        end
        IDX_IF_PD: if (r_reg.w_be) r_next.if_pd = r_reg.w_data;
        IDX_LANE_PD: if (r_reg.w_be) r_next.lane_pd = r_reg.w_data;
        IDX_CDR_RST: if (r_reg.w_be) r_next.cdr_rst = r_reg.w_data;
        IDX_SAMP: if (r_reg.w_be) r_next.samp = r_reg.w_data;
        IDX_EQ: if (r_reg.w_be) r_next.eq = r_reg.w_data;
        IDX_PLL_CTL: if (r_reg.w_be) r_next.pll_ctl = r_reg.w_data;
        IDX_DIV: if (r_reg.w_be) r_next.div = r_reg.w_data;
        IDX_FRAME: if (r_reg.w_be) r_next.frame = r_reg.w_data;
        IDX_PLL_ST: r_next.bresp = RESP_OKAY; // Read-only, write ignored
        default: begin
          if (wslot != 5'h00) begin
            if (r_reg.w_be) begin
              r_next.tune[wslot - 5'h01] = r_reg.w_data;
            end
          end else begin
            r_next.bresp = RESP_SLVERR; // Unmapped address
          end
        end
      endcase
    end
    r_next.awready = !r_next.aw_got && !r_next.bvalid;
    r_next.wready = !r_next.w_got && !r_next.bvalid;
    // Read: answer one cycle after the address is taken
    if (r_reg.rvalid && i_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (i_arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      unique case (ridx)
        IDX_INT_EN: r_next.rdata = r_reg.int_en;
        IDX_INT_ST: r_next.rdata = r_reg.int_st;
        IDX_IF_PD: r_next.rdata = r_reg.if_pd;
        IDX_LANE_PD: r_next.rdata = r_reg.lane_pd;
        IDX_CDR_RST: r_next.rdata = r_reg.cdr_rst;
        IDX_SAMP: r_next.rdata = r_reg.samp;
        IDX_EQ: r_next.rdata = r_reg.eq;
        IDX_PLL_CTL: r_next.rdata = r_reg.pll_ctl;
        IDX_DIV: r_next.rdata = r_reg.div;
        IDX_FRAME: r_next.rdata = r_reg.frame;
        // Live PLL state: lock, calibration and band edges
        IDX_PLL_ST: begin
          r_next.rdata = 8'h00;
          r_next.rdata[LOCK_BIT] = r_reg.locked;
          r_next.rdata[CAL_OK_BIT] = r_reg.cal_ok;
          r_next.rdata[BAND_HI_BIT] = r_reg.filt[1];
          r_next.rdata[BAND_LO_BIT] = r_reg.filt[2];
        end
        default: begin
          r_next.rdata = 8'h00;
          if (rslot != 5'h00) begin
            r_next.rdata = r_reg.tune[rslot - 5'h01];
          end else begin
            r_next.rresp = RESP_SLVERR;
          end
        end
      endcase
    end
    r_next.arready = !r_next.rvalid;
    // Calibration restarts on enable or on a rising recalibrate bit
    r_next.en_prev = r_reg.pll_ctl[PLL_EN_BIT];
    r_next.recal_prev = r_reg.pll_ctl[RECAL_BIT];
    start_ev = (r_reg.pll_ctl[PLL_EN_BIT] && !r_reg.en_prev) ||
               (r_reg.pll_ctl[RECAL_BIT] && !r_reg.recal_prev);
    r_next.cal_start = 1'b0;
    if (!r_reg.pll_ctl[PLL_EN_BIT]) begin
      r_next.cal_state = CAL_IDLE;
      r_next.cal_ok = 1'b0;
    end else if (start_ev) begin
      r_next.cal_state = CAL_RUN;
      r_next.cal_cnt = '0;
      r_next.cal_ok = 1'b0;
      r_next.cal_start = 1'b1;
    end else begin
      unique case (r_reg.cal_state)
        CAL_IDLE: r_next.cal_state = CAL_IDLE;
        CAL_RUN: begin
          if (r_reg.cal_cnt == CNT_W'(CAL_CYCLES - 1)) begin
            r_next.cal_state = CAL_DONE;
            r_next.cal_ok = 1'b1;
          end else begin
            r_next.cal_cnt = r_reg.cal_cnt + 1'b1;
          end
        end
        CAL_DONE: r_next.cal_state = CAL_DONE;
        default: r_next.cal_state = CAL_IDLE; // Spare code recovers
      endcase
    end
    // Lock counts only on an enabled, calibrated PLL
    r_next.locked = r_reg.filt[0] && r_next.cal_ok &&
                    r_next.pll_ctl[PLL_EN_BIT];
    lock_ev = r_next.locked && !r_reg.locked;
    lost_ev = !r_next.locked && r_reg.locked;
    // Sets come after the clear so an event in the clear cycle survives
    if (lock_ev && r_reg.int_en[IRQ_LOCK_BIT]) begin
      r_next.int_st[IRQ_LOCK_BIT] = 1'b1;
    end
    if (lost_ev && r_reg.int_en[IRQ_LOST_BIT]) begin
      r_next.int_st[IRQ_LOST_BIT] = 1'b1;
    end
    // Registered outputs; no range check on divider vs sampling bands
    r_next.if_pd_o = r_next.if_pd[0];
    r_next.lane_pd_o = r_next.lane_pd | {LANES{r_next.if_pd[0]}};
    r_next.pll_en_o = r_next.pll_ctl[PLL_EN_BIT];
    r_next.div_sel_o = r_next.div[1:0];
    r_next.ratio_o = ref_ratio(r_next.div[1:0]);
    r_next.half_o = r_next.samp[HALF_BIT];
    r_next.ovs_o = r_next.samp[OVS_BIT];
    r_next.eq_o = r_next.eq[EQ_LSB+1:EQ_LSB];
    r_next.fpp_o = frames_per_pclk(r_next.frame);
  end

  // Per-lane recovery reset: each lane runs once the PLL clock it samples
  // with is locked, the lane is powered and the shared CDR reset bit is clear
  logic [LANES-1:0] lane_hold;
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign lane_hold[g] = r_next.cdr_rst[CDR_RST_BIT] ||
                          r_next.lane_pd_o[g] || !r_next.locked;
  end

  // State register; asynchronous reset loads constants only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '0;
      r_reg.int_en <= RST_VAL;
      r_reg.if_pd <= RST_IF_PD;
      r_reg.if_pd_o <= 1'b1;
      r_reg.lane_pd_o <= {LANES{1'b1}};
      r_reg.cdr_rst_o <= {LANES{1'b1}};
      r_reg.frame <= RST_FRAME;
      r_reg.fpp_o <= 3'(BYTES_PER_PCLK);
      r_reg.ratio_o <= 3'h4;
      r_reg.cal_state <= CAL_IDLE;
    end else begin
      r_reg <= r_next;
      r_reg.cdr_rst_o <= lane_hold;
    end
  end

  // Every output but the fixed VCO post divide comes straight from the state register
  assign o_awready = r_reg.awready;
  assign o_wready = r_reg.wready;
  assign o_bvalid = r_reg.bvalid;
  assign o_bresp = r_reg.bresp;
  assign o_arready = r_reg.arready;
  assign o_rvalid = r_reg.rvalid;
  assign o_rdata = {24'h000000, r_reg.rdata};
  assign o_rresp = r_reg.rresp;
  assign o_if_power_down = r_reg.if_pd_o;
  assign o_lane_power_down = r_reg.lane_pd_o;
  assign o_pll_enable = r_reg.pll_en_o;
  assign o_pll_divider_select = r_reg.div_sel_o;
  assign o_reference_divide_ratio = r_reg.ratio_o;
  assign o_vco_post_divide = VCO_POST_DIV;
  assign o_cal_start = r_reg.cal_start;
  assign o_pll_locked = r_reg.locked;
  assign o_half_rate_sampling_on = r_reg.half_o;
  assign o_double_oversampling_on = r_reg.ovs_o;
  assign o_lane_cdr_reset = r_reg.cdr_rst_o;
  assign o_equalizer_power_select = r_reg.eq_o;
  assign o_frames_per_processing_clock = r_reg.fpp_o;

  // Checks on the block's own behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_div_ratio;
    o_pll_divider_select == DIV_SEL_1 |-> o_reference_divide_ratio == 3'h1;
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("ratio bad");

  property p_cal_done;
    $rose(r_reg.cal_ok) |-> $past(r_reg.cal_state) == CAL_RUN &&
      $past(r_reg.cal_cnt) == CNT_W'(CAL_CYCLES - 1);
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("early cal");

  property p_lock_cal;
    o_pll_locked |-> r_reg.cal_ok && o_pll_enable;
  endproperty
  a_lock_cal: assert property (p_lock_cal) else $error("lock uncal");

  property p_recal;
    r_reg.pll_ctl[RECAL_BIT] && !r_reg.recal_prev &&
      r_reg.pll_ctl[PLL_EN_BIT] |=> o_cal_start ##1 !o_cal_start;
  endproperty
  a_recal: assert property (p_recal) else $error("no recal start");

  property p_irq_lock;
    $rose(o_pll_locked) && $past(r_reg.int_en[IRQ_LOCK_BIT]) |->
      r_reg.int_st[IRQ_LOCK_BIT];
  endproperty
  a_irq_lock: assert property (p_irq_lock) else $error("lock event lost");

  property p_irq_lost;
    $rose(r_reg.int_st[IRQ_LOST_BIT]) |-> $fell(o_pll_locked) &&
      $past(r_reg.int_en[IRQ_LOST_BIT]);
  endproperty
  a_irq_lost: assert property (p_irq_lost) else $error("stray lost");

  property p_if_pd;
    o_if_power_down |-> o_lane_power_down == {LANES{1'b1}};
  endproperty
  a_if_pd: assert property (p_if_pd) else $error("lane on while off");

  property p_cdr_hold;
    !o_pll_locked |-> o_lane_cdr_reset == {LANES{1'b1}};
  endproperty
  a_cdr_hold: assert property (p_cdr_hold) else $error("cdr runs unlocked");

  property p_bresp;
    r_reg.aw_got && r_reg.w_got && !o_bvalid |=> o_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("no write response");

  property p_rd;
    i_arvalid && o_arready |=> o_rvalid ##0 !o_arready;
  endproperty
  a_rd: assert property (p_rd) else $error("no read answer");

  c_lock: cover property ($rose(o_pll_locked));
  c_recal: cover property (o_cal_start && r_reg.recal_prev);
  c_w1c: cover property ($fell(r_reg.int_st[IRQ_LOCK_BIT]));
endmodule
`default_nettype wire

// [bench/scl_pll_model.sv]
// Behavioural model of the analog SERDES PLL core behind the control block
`timescale 1ns/1ns
`default_nettype none
module scl_pll_model #(
  parameter int LOCK_CYC = 40 // Settle time after a calibration start
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pll_enable,
  input wire logic i_cal_start,
  input wire logic i_drop_lock,
  input wire logic [1:0] i_band_req,
  output logic o_lock_det,
  output logic o_band_hi,
  output logic o_band_lo
);
  int cnt; // Cycles left in the running calibration
  logic cal_done; // Loop has settled since the last start
  // A start pulse restarts the loop and recentres the band
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      cal_done <= 1'b0;
      o_band_hi <= 1'b0;
      o_band_lo <= 1'b0;
    end else if (!i_pll_enable) begin
      // Disabled loop never settles, whatever was written before
      cnt <= 0;
      cal_done <= 1'b0;
    end else if (i_cal_start) begin
      cnt <= LOCK_CYC;
      cal_done <= 1'b0;
      o_band_hi <= 1'b0;
      o_band_lo <= 1'b0;
    end else begin
      // Band-edge flags stick until the next calibration
      o_band_hi <= o_band_hi | i_band_req[0];
      o_band_lo <= o_band_lo | i_band_req[1];
      if (cnt == 1) begin
        cal_done <= 1'b1;
      end
      if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Lock only when enabled, settled and not disturbed by the bench
  assign o_lock_det = i_pll_enable && cal_done && !i_drop_lock;
endmodule
`default_nettype wire

// [bench/scl_top_tb.sv]
// Self-checking bench for the SERDES clocking control block
`timescale 1ns/1ns
`default_nettype none
module scl_top_tb;
  import scl_pkg::*;
  // One table row: register, value written, readback, port view
  typedef struct packed {
    logic [11:0] idx;
    logic [7:0] d;
    logic [7:0] rd;
    logic [7:0] pv;
  } scl_row_type;
  localparam int NROW = 18;
  localparam scl_row_type ROWS [NROW] = '{
    '{IDX_IF_PD, 8'h00, 8'h00, 8'h00},
    '{IDX_LANE_PD, 8'hA5, 8'hA5, 8'hA5},
    '{IDX_DIV, 8'h02, 8'h02, 8'h01},
    '{IDX_DIV, 8'h01, 8'h01, 8'h02},
    '{IDX_DIV, 8'h00, 8'h00, 8'h04},
    '{IDX_SAMP, 8'h02, 8'h02, 8'h01},
    '{IDX_SAMP, 8'h00, 8'h00, 8'h00},
    '{IDX_SAMP, 8'h20, 8'h20, 8'h02},
    '{IDX_EQ, 8'h00, 8'h00, 8'h00},
    '{IDX_EQ, 8'h40, 8'h40, 8'h01},
    '{IDX_FRAME, 8'h01, 8'h01, 8'h04},
    '{IDX_FRAME, 8'h02, 8'h02, 8'h02},
    '{IDX_FRAME, 8'h04, 8'h04, 8'h01},
    '{IDX_CDR_RST, 8'h01, 8'h01, 8'hFF},
    '{12'h284, 8'h62, 8'h62, 8'h00},
    '{12'h285, 8'hC9, 8'hC9, 8'h00},
    '{12'h2A0, 8'h06, 8'h06, 8'h00},
    '{IDX_PLL_ST, 8'hFF, 8'h00, 8'h00}
  };
  logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [ADDR_W-1:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb; // Full strobes: only the low byte matters
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic i_pll_lock_det, i_cal_band_hi, i_cal_band_lo;
  logic o_if_power_down, o_pll_enable, o_cal_start, o_pll_locked;
  logic o_half_rate_sampling_on, o_double_oversampling_on;
  logic [LANES-1:0] o_lane_power_down, o_lane_cdr_reset;
  logic [1:0] o_pll_divider_select, o_vco_post_divide;
  logic [1:0] o_equalizer_power_select, band_req;
  logic [2:0] o_reference_divide_ratio, o_frames_per_processing_clock;
  logic drop; // Bench command: disturb the loop
  int err_total, check_count, cyc, starts;
  logic [7:0] rd; // Last read data
  logic [1:0] rsp; // Last response code
  scl_top i_dut (.i_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
    .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .i_pll_lock_det, .i_cal_band_hi,
    .i_cal_band_lo, .o_if_power_down, .o_lane_power_down, .o_pll_enable,
    .o_pll_divider_select, .o_reference_divide_ratio, .o_vco_post_divide,
    .o_cal_start, .o_pll_locked, .o_half_rate_sampling_on,
    .o_double_oversampling_on, .o_lane_cdr_reset,
    .o_equalizer_power_select, .o_frames_per_processing_clock);
  scl_pll_model i_pll (.i_clk, .i_rst, .i_pll_enable(o_pll_enable),
    .i_cal_start(o_cal_start), .i_drop_lock(drop), .i_band_req(band_req),
    .o_lock_det(i_pll_lock_det), .o_band_hi(i_cal_band_hi),
    .o_band_lo(i_cal_band_lo));
  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Calibration start pulses seen so far
  always @(posedge i_clk) begin
    if (o_cal_start === 1'b1) starts++;
  end
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  // AXI4-Lite write: address and data offered together, each released
  // when taken; bready held until the response is seen
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    i_awaddr <= {idx, 2'b00};
    i_wdata <= {24'h000000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    rsp = o_bresp;
    i_bready <= 1'b0;
  endtask
  // AXI4-Lite read of one register word
  task automatic rdr(input logic [11:0] idx);
    @(posedge i_clk);
    i_araddr <= {idx, 2'b00};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
    rd = o_rdata[7:0];
    rsp = o_rresp;
    i_rready <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] idx,
                      input logic [7:0] e);
    rdr(idx);
    chk(nm, e, rd);
  endtask
  // Bounded wait for the lock level; missing it shows as a mismatch
  task automatic wait_lock(input logic e);
    int n;
    n = 0;
    while (o_pll_locked !== e && n < 1500) begin
      @(posedge i_clk);
      n++;
    end
    chk("o_pll_locked", e, o_pll_locked);
  endtask
  // Port view of the setting that a register drives
  function automatic logic [7:0] obs(input logic [11:0] idx);
    case (idx)
      IDX_IF_PD: obs = {7'h00, o_if_power_down};
      IDX_LANE_PD: obs = o_lane_power_down;
      IDX_DIV: obs = {5'h00, o_reference_divide_ratio};
      IDX_SAMP: obs = {6'h00, o_half_rate_sampling_on,
                       o_double_oversampling_on};
      IDX_EQ: obs = {6'h00, o_equalizer_power_select};
      IDX_FRAME: obs = {5'h00, o_frames_per_processing_clock};
      IDX_CDR_RST: obs = o_lane_cdr_reset;
      default: obs = {7'h00, o_pll_locked};
    endcase
  endfunction
  initial begin
    i_rst = 1'b1;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    i_awaddr = '0;
    i_araddr = '0;
    i_wdata = 32'h00000000;
    i_wstrb = 4'hF;
    drop = 1'b0;
    band_req = 2'h0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    chk("o_lane_power_down", 8'hFF, o_lane_power_down);
    chk("o_vco_post_divide", VCO_POST_DIV, o_vco_post_divide);
    rchk("if_power_down", IDX_IF_PD, RST_IF_PD);
    rchk("frame_octets", IDX_FRAME, RST_FRAME);
    rchk("interrupt_enable", IDX_INT_EN, RST_VAL);
    note("reset values");
    for (int i = 0; i < NROW; i++) begin
      wr(ROWS[i].idx, ROWS[i].d);
      chk("write response", RESP_OKAY, rsp);
      repeat (2) @(posedge i_clk);
      chk($sformatf("port of %h", ROWS[i].idx), ROWS[i].pv,
          obs(ROWS[i].idx));
      rchk($sformatf("reg %h", ROWS[i].idx), ROWS[i].idx,
           ROWS[i].rd);
    end
    note("register table");
    // Unmapped place answers an error and reads zero
    wr(12'h3FF, 8'h55);
    chk("unmapped write", RESP_SLVERR, rsp);
    rdr(12'h3FF);
    chk("unmapped read", {RESP_SLVERR, 8'h00}, {rsp, rd});
    note("unmapped");
    // A write with the low byte lane off is answered but changes nothing
    i_wstrb <= 4'hE;
    wr(IDX_EQ, 8'hC0);
    i_wstrb <= 4'hF;
    chk("masked write response", RESP_OKAY, rsp);
    rchk("masked write", IDX_EQ, 8'h40);
    note("masked write");
    // Divider already holds divide-by-4; enable after it
    wr(IDX_CDR_RST, 8'h00);
    wr(IDX_INT_EN, 8'h04);
    wr(IDX_PLL_CTL, 8'h01);
    repeat (2) @(posedge i_clk);
    chk("o_pll_enable", 1'b1, o_pll_enable);
    chk("o_pll_divider_select", DIV_SEL_4, o_pll_divider_select);
    wait_lock(1'b1);
    chk("calibration starts", 1, starts);
    rchk("pll_lock_status", IDX_PLL_ST, 8'h09);
    rchk("interrupt_status", IDX_INT_ST, 8'h04);
    chk("o_lane_cdr_reset", 8'hA5, o_lane_cdr_reset);
    wr(IDX_INT_ST, 8'h04);
    rchk("interrupt_status", IDX_INT_ST, 8'h00);
    note("pll lock");
    // Loss while its event is masked leaves no trace
    drop <= 1'b1;
    wait_lock(1'b0);
    rchk("interrupt_status", IDX_INT_ST, 8'h00);
    drop <= 1'b0;
    wait_lock(1'b1);
    rchk("interrupt_status", IDX_INT_ST, 8'h04);
    wr(IDX_INT_EN, 8'h0C);
    wr(IDX_INT_ST, 8'h04);
    drop <= 1'b1;
    wait_lock(1'b0);
    rchk("interrupt_status", IDX_INT_ST, 8'h08);
    note("lock events");
    band_req <= 2'h3;
    repeat (8) @(posedge i_clk);
    band_req <= 2'h0;
    rchk("pll_lock_status", IDX_PLL_ST, 8'h38);
    drop <= 1'b0;
    wr(IDX_PLL_CTL, 8'h01);
    wr(IDX_PLL_CTL, 8'h05);
    repeat (4) @(posedge i_clk);
    chk("calibration starts", 2, starts);
    repeat (20) @(posedge i_clk);
    wait_lock(1'b1);
    rchk("pll_lock_status", IDX_PLL_ST, 8'h09);
    note("recalibration");
    // Disabling the loop drops lock and forgets the calibration
    wr(IDX_PLL_CTL, 8'h00);
    repeat (2) @(posedge i_clk);
    chk("o_pll_enable", 1'b0, o_pll_enable);
    rchk("pll_lock_status", IDX_PLL_ST, 8'h00);
    note("pll disable");
    // Reset in mid-run returns everything to the safe state
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("o_if_power_down", 1'b1, o_if_power_down);
    chk("o_lane_power_down", 8'hFF, o_lane_power_down);
    chk("o_lane_cdr_reset", 8'hFF, o_lane_cdr_reset);
    chk("o_pll_locked", 1'b0, o_pll_locked);
    chk("o_frames", 3'h4, o_frames_per_processing_clock);
    i_rst <= 1'b0;
    rchk("equalizer_mode", IDX_EQ, RST_VAL);
    note("mid-run reset");
    results();
  end
endmodule
`default_nettype wire
